/* File: rtl/rx_agc_pkg.sv */
// Function
// - The receive setting register loads 0x40 at power-on reset and whenever chip enable is low.
// - Every write to the protocol-selection register at index 0x01 reloads the receive setting default.
// - With bits 7 to 4 all clear the receiver uses its wide band-pass characteristic.
// - Bit 7 picks the 212 kHz band, bit 6 the 200 to 900 kHz band, bit 5 the Manchester 848 kHz band.
// - Bit 4 picks the widest band for the highest bit rate and adds an 18 dB gain cut.
// - Bits 3 and 2 give a gain cut of 0, 5, 10 or 15 dB for codes 00, 01, 10, 11.
// - Bit 1 clear starts the AGC at five times the digitizer threshold, set at three times.
// - Bit 0 clear lets the AGC adjust only in the first 8 subcarrier pulses, set lets it adjust throughout.
// - The AGC loop runs only while the agc-on bit 2 of the chip status control register is set.
// - While enabled the AGC watches the digitizer input level and cuts gain above the chosen multiple.
// - The AGC takes four comparator-adjustment steps first, then three gain-reduction steps.
// - The AGC starts only after a transmission has ended, never during it.
package rx_agc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CHIP_STATUS = 8'h00;
  localparam logic [7:0] IDX_PROTOCOL    = 8'h01;
  localparam logic [7:0] IDX_RX_SETTING  = 8'h0A;
  localparam logic [7:0] IDX_AGC_STATUS  = 8'h10;
  localparam logic [9:0] ADDR_CHIP_STATUS = {IDX_CHIP_STATUS, 2'b00};
  localparam logic [9:0] ADDR_PROTOCOL    = {IDX_PROTOCOL, 2'b00};
  localparam logic [9:0] ADDR_RX_SETTING  = {IDX_RX_SETTING, 2'b00};
  localparam logic [9:0] ADDR_AGC_STATUS  = {IDX_AGC_STATUS, 2'b00};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_SETTING_RST  = 8'h40;
  localparam logic [7:0] CHIP_STATUS_RST = 8'h00;
  localparam logic [7:0] PROTOCOL_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BAND_212K   = 7;
  localparam int unsigned BIT_BAND_424K   = 6;
  localparam int unsigned BIT_BAND_BAND_MANCHESTER_848K_SELECT   = 5;
  localparam int unsigned BIT_HIGH_RATE   = 4;
  localparam int unsigned BIT_GAIN_MSB    = 3;
  localparam int unsigned BIT_GAIN_LSB    = 2;
  localparam int unsigned BIT_AGC_LEVEL   = 1;
  localparam int unsigned BIT_NO_LIMIT    = 0;
  localparam int unsigned BIT_AGC_ON      = 2;
  localparam int unsigned BIT_STAT_FROZEN = 5;
  localparam int unsigned BIT_STAT_ACTIVE = 6;

  // ----------------------------------------------------------------
  // Gain cut figures in dB, AGC window length in pulses and AGC step counts
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_CUT_STEP_DB = 4'h5;
  localparam logic [3:0] HOLD_PULSES      = 4'h8;
  localparam logic [2:0] COMP_STEPS       = 3'h4;
  localparam logic [1:0] GAIN_STEPS       = 2'h3;

  // ----------------------------------------------------------------
  // Bus answers and AGC states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    AGC_IDLE    = 4'b0001,
    AGC_WAIT_RX = 4'b0010,
    AGC_COMP    = 4'b0100,
    AGC_GAIN    = 4'b1000
  } agc_state_t;

endpackage

/* File: rtl/agc_sequencer.sv */
`timescale 1ns/10ps
module agc_sequencer
  import rx_agc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       agc_enable,
  input  wire logic       no_limit,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  input  wire logic       subcarrier_pulse,
  input  wire logic       level_over,
  output logic [2:0]      comp_step,
  output logic [1:0]      gain_step,
  output logic            agc_frozen,
  output logic            agc_active
);

  agc_state_t state_reg;
  logic [3:0] pulse_cnt_reg;
  logic       tx_active_d_reg;

  // ----------------------------------------------------------------
  // Decode of window and events
  // ----------------------------------------------------------------
  wire tx_end      = tx_active_d_reg & ~tx_active;
  wire window_open = no_limit | (pulse_cnt_reg < HOLD_PULSES);
  wire in_rx       = (state_reg == AGC_COMP) | (state_reg == AGC_GAIN);
  wire step_now    = in_rx & subcarrier_pulse & level_over & window_open;
  wire gain_full   = (gain_step == GAIN_STEPS);

  // Sequencer: arm after TX, comparator steps then gain steps
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !agc_enable || tx_active)
    begin
      state_reg     <= AGC_IDLE;
      comp_step     <= 3'h0;
      gain_step     <= 2'h0;
      pulse_cnt_reg <= 4'h0;
    end
    else
    begin
      unique case (state_reg)
        AGC_IDLE:
          if (tx_end) state_reg <= AGC_WAIT_RX;
        AGC_WAIT_RX:
          if (rx_active)
          begin
            state_reg     <= AGC_COMP;
            pulse_cnt_reg <= 4'h0;
          end
        AGC_COMP:
          if (!rx_active) state_reg <= AGC_IDLE;
          else if (step_now)
          begin
            comp_step <= comp_step + 3'h1;
            if (comp_step == COMP_STEPS - 3'h1) state_reg <= AGC_GAIN;
          end
        AGC_GAIN:
          if (!rx_active) state_reg <= AGC_IDLE;
          else if (step_now && !gain_full) gain_step <= gain_step + 2'h1;
        default:
          state_reg <= AGC_IDLE;
      endcase
      if (in_rx && subcarrier_pulse && pulse_cnt_reg < HOLD_PULSES)
        pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
    end
  end

  // Edge memory and status flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_active_d_reg <= 1'b0;
      agc_frozen      <= 1'b0;
      agc_active      <= 1'b0;
    end
    else
    begin
      tx_active_d_reg <= tx_active;
      agc_frozen      <= in_rx & ~window_open;
      agc_active      <= in_rx;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_idle_during_tx: assert property (tx_active |=> state_reg == AGC_IDLE)
    else $error("AGC left idle during transmission");
  chk_step_order: assert property (gain_step != 2'h0 |-> comp_step == COMP_STEPS)
    else $error("gain step taken before comparator steps finished");
  chk_window_freeze: assert property (
    (in_rx && !no_limit && pulse_cnt_reg == HOLD_PULSES && agc_enable && !tx_active)
    |=> $stable(comp_step) && $stable(gain_step))
    else $error("AGC adjusted after the 8-pulse window");
  chk_enable_gate: assert property (!agc_enable |=> state_reg == AGC_IDLE && comp_step == 3'h0)
    else $error("AGC ran while disabled");
  chk_step_cause: assert property (
    (state_reg == AGC_COMP && !level_over && agc_enable && !tx_active) |=> $stable(comp_step))
    else $error("comparator step without level over threshold");

  cov_full_gain: cover property (gain_step == GAIN_STEPS);
  cov_frozen:    cover property (agc_frozen && comp_step != 3'h0);
  cov_after_tx:  cover property (tx_end ##[1:50] state_reg == AGC_COMP);

endmodule

/* File: rtl/rx_filter_gain_agc_control.sv */
`timescale 1ns/10ps
module rx_filter_gain_agc_control
  import rx_agc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Chip enable pin and receive path status
  input  wire logic        chip_enable,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        subcarrier_pulse,
  input  wire logic        level_over_3x,
  input  wire logic        level_over_5x,
  // Filter and gain controls to the analogue stages
  output logic             band_wide_select,
  output logic             band_212k_select,
  output logic             band_424k_select,
  output logic             band_manchester_848k_select,
  output logic             band_high_rate_select,
  output logic             gain_cut_18db,
  output logic [3:0]       gain_reduce_db,
  output logic             agc_level_3x,
  output logic             agc_loop_on,
  output logic [2:0]       agc_comp_step,
  output logic [1:0]       agc_gain_step
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  rx_setting_reg;
  logic [7:0]  chip_status_reg;
  logic [7:0]  protocol_reg;
  logic [9:0]  waddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic        agc_frozen;
  logic        agc_active;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire b_fire   = s_axi_bvalid & s_axi_bready;
  wire ar_fire  = s_axi_arvalid & s_axi_arready;
  wire r_fire   = s_axi_rvalid & s_axi_rready;
  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;

  // Write address decode
  wire wr_chip_status = do_write & (waddr_reg == ADDR_CHIP_STATUS);
  wire wr_protocol    = do_write & (waddr_reg == ADDR_PROTOCOL);
  wire wr_rx_setting  = do_write & (waddr_reg == ADDR_RX_SETTING);
  wire wr_agc_status  = do_write & (waddr_reg == ADDR_AGC_STATUS);
  wire wr_mapped      = wr_chip_status | wr_protocol | wr_rx_setting | wr_agc_status;

  // Read address decode
  wire rd_chip_status = (s_axi_araddr == ADDR_CHIP_STATUS);
  wire rd_protocol    = (s_axi_araddr == ADDR_PROTOCOL);
  wire rd_rx_setting  = (s_axi_araddr == ADDR_RX_SETTING);
  wire rd_agc_status  = (s_axi_araddr == ADDR_AGC_STATUS);
  wire rd_mapped      = rd_chip_status | rd_protocol | rd_rx_setting | rd_agc_status;

  // AGC status word
  wire [7:0] agc_status_word = {1'b0, agc_active, agc_frozen, agc_gain_step, agc_comp_step};

  // Read data selection
  wire [7:0] rd_byte = rd_chip_status ? chip_status_reg :
                       rd_protocol    ? protocol_reg    :
                       rd_rx_setting  ? rx_setting_reg  :
                       rd_agc_status  ? agc_status_word : 8'h00;

  // Level comparator chosen by the activation bit
  wire level_over = rx_setting_reg[BIT_AGC_LEVEL] ? level_over_3x : level_over_5x;

  // Gain cut from the two-bit field
  wire [1:0] gain_code = {rx_setting_reg[BIT_GAIN_MSB], rx_setting_reg[BIT_GAIN_LSB]};
  wire [3:0] gain_db_next = (gain_code == 2'h0) ? 4'h0 :
                            (gain_code == 2'h1) ? GAIN_CUT_STEP_DB :
                            (gain_code == 2'h2) ? 4'(GAIN_CUT_STEP_DB * 2) :
                                                  4'(GAIN_CUT_STEP_DB * 3);

  // ----------------------------------------------------------------
  // Write channel acceptance
  // ----------------------------------------------------------------
  // Address and data are latched independently, in any order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      waddr_reg     <= 10'h000;
      wdata_reg     <= 8'h00;
      wstrb0_reg    <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        s_axi_awready <= 1'b0;
        aw_full_reg   <= 1'b1;
        waddr_reg     <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full_reg <= 1'b0;
      else if (b_fire)
        s_axi_awready <= 1'b1;
      if (w_fire)
      begin
        s_axi_wready <= 1'b0;
        w_full_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata[7:0];
        wstrb0_reg   <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_full_reg <= 1'b0;
      else if (b_fire)
        s_axi_wready <= 1'b1;
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (b_fire)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read at a time; data registered at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_fire)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Receive setting: default on reset, chip disable or protocol write
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !chip_enable)
      rx_setting_reg <= RX_SETTING_RST;
    else if (wr_protocol)
      rx_setting_reg <= RX_SETTING_RST;
    else if (wr_rx_setting && wstrb0_reg)
      rx_setting_reg <= wdata_reg;
  end

  // Chip status control and protocol selection
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !chip_enable)
    begin
      chip_status_reg <= CHIP_STATUS_RST;
      protocol_reg    <= PROTOCOL_RST;
    end
    else
    begin
      if (wr_chip_status && wstrb0_reg)
        chip_status_reg <= wdata_reg;
      if (wr_protocol && wstrb0_reg)
        protocol_reg <= wdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // Filter and gain outputs
  // ----------------------------------------------------------------
  // Registered decode of the receive setting and the AGC-on bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      band_wide_select            <= 1'b0;
      band_212k_select            <= 1'b0;
      band_424k_select            <= 1'b1;
      band_manchester_848k_select <= 1'b0;
      band_high_rate_select       <= 1'b0;
      gain_cut_18db               <= 1'b0;
      gain_reduce_db              <= 4'h0;
      agc_level_3x                <= 1'b0;
      agc_loop_on                 <= 1'b0;
    end
    else
    begin
      band_wide_select            <= (rx_setting_reg[7:4] == 4'h0);
      band_212k_select            <= rx_setting_reg[BIT_BAND_212K];
      band_424k_select            <= rx_setting_reg[BIT_BAND_424K];
      band_manchester_848k_select <= rx_setting_reg[BIT_BAND_BAND_MANCHESTER_848K_SELECT];
      band_high_rate_select       <= rx_setting_reg[BIT_HIGH_RATE];
      gain_cut_18db               <= rx_setting_reg[BIT_HIGH_RATE];
      gain_reduce_db              <= gain_db_next;
      agc_level_3x                <= rx_setting_reg[BIT_AGC_LEVEL];
      agc_loop_on                 <= chip_status_reg[BIT_AGC_ON];
    end
  end

  // ----------------------------------------------------------------
  // AGC step sequencer
  // ----------------------------------------------------------------
  agc_sequencer u_agc (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .agc_enable       (chip_status_reg[BIT_AGC_ON]),
    .no_limit         (rx_setting_reg[BIT_NO_LIMIT]),
    .tx_active        (tx_active),
    .rx_active        (rx_active),
    .subcarrier_pulse (subcarrier_pulse),
    .level_over       (level_over),
    .comp_step        (agc_comp_step),
    .gain_step        (agc_gain_step),
    .agc_frozen       (agc_frozen),
    .agc_active       (agc_active)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_disable_default: assert property (!chip_enable |=> rx_setting_reg == RX_SETTING_RST)
    else $error("receive setting not defaulted on chip disable");
  chk_protocol_reload: assert property (wr_protocol && chip_enable |=> rx_setting_reg == RX_SETTING_RST)
    else $error("protocol write did not reload receive setting");
  chk_wide_band: assert property ((rx_setting_reg[7:4] == 4'h0) |=> band_wide_select)
    else $error("wide band not selected with bits 7 to 4 clear");
  chk_band_bits: assert property (##1 band_212k_select == $past(rx_setting_reg[BIT_BAND_212K]) &&
    band_manchester_848k_select == $past(rx_setting_reg[BIT_BAND_BAND_MANCHESTER_848K_SELECT]))
    else $error("band select does not follow setting");
  chk_high_rate_cut: assert property (rx_setting_reg[BIT_HIGH_RATE] |=> gain_cut_18db && band_high_rate_select)
    else $error("high rate band lacks 18 dB cut");
  chk_gain_field: assert property (gain_code == 2'h3 |=> gain_reduce_db == 4'hF)
    else $error("gain field 11 does not give 15 dB");
  chk_gain_zero: assert property (gain_code == 2'h0 |=> gain_reduce_db == 4'h0)
    else $error("gain field 00 does not give 0 dB");
  chk_level_select: assert property (##1 agc_level_3x == $past(rx_setting_reg[BIT_AGC_LEVEL]))
    else $error("3x threshold not selected");
  chk_readback_value: assert property (ar_fire && rd_rx_setting |=> s_axi_rvalid &&
    s_axi_rdata[7:0] == $past(rx_setting_reg))
    else $error("receive setting read back wrong");
  chk_write_lands: assert property (wr_rx_setting && wstrb0_reg && chip_enable |=>
    rx_setting_reg == $past(wdata_reg))
    else $error("direct write to receive setting lost");
  chk_no_strobe_keep: assert property (wr_rx_setting && !wstrb0_reg && chip_enable |=>
    $stable(rx_setting_reg))
    else $error("setting changed without strobe");

  // Remaining decode outputs against setting and AGC-on bit
  chk_band_424k: assert property (##1 band_424k_select == $past(rx_setting_reg[BIT_BAND_424K]))
    else $error("424k band does not follow setting");
  chk_wide_off: assert property ((rx_setting_reg[7:4] != 4'h0) |=> !band_wide_select)
    else $error("wide band kept with band bit set");
  chk_high_rate_off: assert property (!rx_setting_reg[BIT_HIGH_RATE] |=> !gain_cut_18db)
    else $error("18 dB cut without high rate bit");
  chk_gain_five: assert property (gain_code == 2'h1 |=> gain_reduce_db == GAIN_CUT_STEP_DB)
    else $error("gain field 01 not 5 dB");
  chk_gain_ten: assert property (gain_code == 2'h2 |=> gain_reduce_db == 4'hA)
    else $error("gain field 10 not 10 dB");
  chk_loop_on: assert property (##1 agc_loop_on == $past(chip_status_reg[BIT_AGC_ON]))
    else $error("loop enable does not follow status");

  // Bus answers and refusals
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  chk_aw_refused: assert property (aw_full_reg |-> !s_axi_awready)
    else $error("address taken while write pending");
  chk_w_refused: assert property (w_full_reg |-> !s_axi_wready)
    else $error("data taken while write pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while read pending");
  chk_unmapped_read: assert property (ar_fire && !rd_mapped |=>
    s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_slverr_write: assert property (do_write && !wr_mapped |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_bresp_okay: assert property (do_write && wr_mapped |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write refused");

  cov_write_resp: cover property (do_write ##[1:4] b_fire);
  cov_override:   cover property (wr_protocol ##[1:20] wr_rx_setting);

endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import rx_agc_pkg::*;
;
  logic        aclk = 0, aresetn = 0, chip_enable = 1, tx_active = 0, rx_active = 0;
  logic        subcarrier_pulse = 0, level_over_3x = 0, level_over_5x = 0;
  logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0, agc_comp_step;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0, gain_reduce_db;
  logic [1:0]  s_axi_bresp, s_axi_rresp, agc_gain_step;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        band_wide_select, band_212k_select, band_424k_select, band_manchester_848k_select;
  logic        band_high_rate_select, gain_cut_18db, agc_level_3x, agc_loop_on;
  logic [7:0]  v;
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  int          fails = 0, total_checks = 0;

  rx_filter_gain_agc_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chip_enable, .tx_active, .rx_active, .subcarrier_pulse, .level_over_3x,
    .level_over_5x, .band_wide_select, .band_212k_select, .band_424k_select, .band_manchester_848k_select,
    .band_high_rate_select, .gain_cut_18db, .gain_reduce_db, .agc_level_3x, .agc_loop_on, .agc_comp_step,
    .agc_gain_step);

  // Clock at 50 ns
  always #25 aclk = ~aclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp)
      begin
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        fails++;
      end
    end
  endtask

  task automatic final_report();
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // AXI4-Lite write, expected response noted
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] rsp);
    logic ta, tw, b;
    begin
      b = 0;
      @(posedge aclk);
      exp_b.push_back(rsp);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!b)
      begin
        @(negedge aclk);
        b  = s_axi_bvalid;
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
    end
  endtask

  // AXI4-Lite read, expected data noted
  task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] rsp);
    logic t, r;
    begin
      r = 0;
      @(posedge aclk);
      exp_r.push_back({rsp, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!r)
      begin
        @(negedge aclk);
        r = s_axi_rvalid;
        t = s_axi_arvalid & s_axi_arready;
        @(posedge aclk);
        if (t) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
    end
  endtask

  // Decoded analogue controls against a setting value
  task automatic dec(input logic [7:0] x);
    begin
      @(posedge aclk);
      @(negedge aclk);
      check("bands", {band_wide_select, band_212k_select, band_424k_select, band_manchester_848k_select,
        band_high_rate_select}, {x[7:4] == 4'h0, x[7:4]});
      check("gain", {gain_cut_18db, gain_reduce_db}, {x[4], x[3:2] * 4'h5});
      check("level", agc_level_3x, x[1]);
    end
  endtask

  task automatic pulse(input int n, input logic l3, input logic l5);
    repeat (n)
    begin
      @(posedge aclk);
      subcarrier_pulse <= 1'b1;
      level_over_3x    <= l3;
      level_over_5x    <= l5;
      @(posedge aclk);
      subcarrier_pulse <= 1'b0;
      level_over_3x    <= 1'b0;
      level_over_5x    <= 1'b0;
    end
  endtask

  // One transmit then receive burst, steps compared at the end
  task automatic agc(input int nq, input int na, input logic l3, input logic l5, input int ec, input int eg);
    begin
      @(posedge aclk);
      tx_active <= 1'b1;
      pulse(4, 1'b1, 1'b1);
      @(negedge aclk);
      check("tx_steps", {agc_comp_step, agc_gain_step}, 5'h00);
      @(posedge aclk);
      tx_active <= 1'b0;
      @(posedge aclk);
      rx_active <= 1'b1;
      @(posedge aclk);
      pulse(nq, 1'b0, 1'b0);
      pulse(na, l3, l5);
      @(posedge aclk);
      @(negedge aclk);
      check("comp_step", agc_comp_step, ec);
      check("gain_step", agc_gain_step, eg);
      @(posedge aclk);
      rx_active <= 1'b0;
    end
  endtask

  // Response monitor, oldest note first
  always @(posedge aclk)
  begin
    logic [33:0] e;
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", s_axi_bresp, exp_b.pop_front());
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = exp_r.pop_front();
      check("rresp", s_axi_rresp, e[33:32]);
      check("rdata", s_axi_rdata, e[31:0]);
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(40));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_RX_SETTING, 32'h0000_0040, RESP_OKAY);
    dec(8'h40);
    for (int i = 0; i < 9; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h1E : (i == 2) ? 8'h84 : (i == 3) ? 8'h28 : 8'($urandom);
      wr(ADDR_RX_SETTING, v, 4'h1, RESP_OKAY);
      rd(ADDR_RX_SETTING, {24'h00_0000, v}, RESP_OKAY);
      dec(v);
    end
    wr(ADDR_RX_SETTING, 8'hFF, 4'h0, RESP_OKAY);
    rd(ADDR_RX_SETTING, {24'h00_0000, v}, RESP_OKAY);
    wr(ADDR_PROTOCOL, 8'h00, 4'h1, RESP_OKAY);
    rd(ADDR_RX_SETTING, 32'h0000_0040, RESP_OKAY);
    wr(ADDR_RX_SETTING, 8'h9C, 4'h1, RESP_OKAY);
    @(posedge aclk);
    chip_enable <= 1'b0;
    @(posedge aclk);
    chip_enable <= 1'b1;
    rd(ADDR_RX_SETTING, 32'h0000_0040, RESP_OKAY);
    wr(10'h3FC, 8'h12, 4'h1, RESP_SLVERR);
    rd(10'h3FC, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_RX_SETTING, 8'h03, 4'h1, RESP_OKAY);
    agc(0, 7, 1'b1, 1'b1, 0, 0);
    check("loop_off", agc_loop_on, 1'b0);
    wr(ADDR_CHIP_STATUS, 8'h04, 4'h1, RESP_OKAY);
    dec(8'h03);
    check("loop_on", agc_loop_on, 1'b1);
    agc(0, 7, 1'b1, 1'b0, 4, 3);
    agc(0, 9, 1'b1, 1'b1, 4, 3);
    wr(ADDR_RX_SETTING, 8'h01, 4'h1, RESP_OKAY);
    agc(0, 7, 1'b1, 1'b0, 0, 0);
    agc(8, 3, 1'b1, 1'b1, 3, 0);
    wr(ADDR_RX_SETTING, 8'h00, 4'h1, RESP_OKAY);
    agc(8, 3, 1'b1, 1'b1, 0, 0);
    agc(6, 5, 1'b1, 1'b1, 2, 0);
    rd(ADDR_AGC_STATUS, 32'h0000_0062, RESP_OKAY);
    final_report();
  end

  // Watchdog
  initial
  begin
    #(50 * 20_000);
    fails++;
    final_report();
  end
endmodule
